// File: bench/mgmt_host_model.sv
// management host model: issues decoded command transfers one at a time
// assumes the supervisor answers every command exactly one cycle after taking it
`timescale 1ns/1ps
module mgmt_host_model (
    input  wire logic                   clk,
    output temp_sup_pkg::cmd_req_t      cmd_req,
    input  wire temp_sup_pkg::cmd_rsp_t cmd_rsp
);
    import temp_sup_pkg::*;
    initial cmd_req = '0;
    // drive after an edge, taken at the next; released fields show inverted junk
    task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data,
                        output cmd_rsp_t rsp);
        @(posedge clk);
        #1 cmd_req = {1'b1, w, code, data};
        @(posedge clk);
        #1 cmd_req = {1'b0, ~w, ~code, ~data};
        rsp = cmd_rsp;
    endtask
endmodule

// File: bench/temp_sup_checker.sv
// checker for the temperature supervisor: command answers, alert, status, sequencer
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module temp_sup_checker #(
    parameter int unsigned RETRY_UNIT_CYC = 10
) (
    input wire logic                            clk,
    input wire logic                            rst_b,
    input wire temp_sup_pkg::cmd_req_t          cmd_req,
    input wire temp_sup_pkg::cmd_rsp_t          cmd_rsp,
    input wire logic [15:0]                     temp_linear,
    input wire logic                            temp_valid,
    input wire logic                            enable_req,
    input wire logic                            other_fault_shutdown,
    input wire logic                            clear_faults,
    input wire logic                            output_enable,
    input wire temp_sup_pkg::temp_status_t      temp_status,
    input wire temp_sup_pkg::supervisor_state_t seq_state,
    input wire logic [2:0]                      retry_count,
    input wire logic                            alert_line_n
);
    import temp_sup_pkg::*;
    // longest legal wait is 8 units plus a cycle; generous so a slow unit still passes
    localparam int WAIT_MAX = 900;
    logic code_known;
    // decoded command codes
    assign code_known = cmd_req.code inside {CODE_OVERTEMP_FAULT_THRESHOLD,
        CODE_OVERTEMP_FAULT_ACTION, CODE_OVERTEMP_WARNING_THRESHOLD,
        CODE_UNDERTEMP_WARNING_THRESHOLD, CODE_UNDERTEMP_FAULT_THRESHOLD};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence cmd_taken; cmd_req.valid; endsequence
    sequence wait_entered; $rose(seq_state == ST_WAIT); endsequence
    ack_follows_a: assert property (cmd_taken |=> cmd_rsp.ack)
        else $error("command not answered next cycle");
    ack_cause_a: assert property (cmd_rsp.ack |-> $past(cmd_req.valid))
        else $error("answer without command");
    refuse_unknown_a: assert property (cmd_taken and !code_known
        |=> cmd_rsp.err && cmd_rsp.rdata == 16'h0000) else $error("unknown code accepted");
    known_ok_a: assert property (cmd_taken and code_known |=> !cmd_rsp.err)
        else $error("known code refused");
    alert_level_a: assert property (alert_line_n == (temp_status == 4'h0))
        else $error("alert does not follow status");
    ot_cause_a: assert property ($rose(temp_status.ot_fault) |-> $past(temp_valid))
        else $error("fault set without valid sample");
    status_sticky_a: assert property (temp_status.ot_fault && !clear_faults
        |=> temp_status.ot_fault) else $error("fault bit lost");
    off_unless_run_a: assert property (seq_state != ST_RUN |-> !output_enable)
        else $error("output on outside run");
    locked_hold_a: assert property (seq_state == ST_LOCKED && enable_req
        && !clear_faults |=> seq_state == ST_LOCKED) else $error("lockout left");
    wait_ends_a: assert property (wait_entered |-> ##[1:WAIT_MAX] seq_state != ST_WAIT)
        else $error("retry wait never ends");
endmodule
bind temperature_fault_supervisor temp_sup_checker #(.RETRY_UNIT_CYC(RETRY_UNIT_CYC)) i_chk (
    .clk(clk), .rst_b(rst_b), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp),
    .temp_linear(temp_linear), .temp_valid(temp_valid), .enable_req(enable_req),
    .other_fault_shutdown(other_fault_shutdown), .clear_faults(clear_faults),
    .output_enable(output_enable), .temp_status(temp_status), .seq_state(seq_state),
    .retry_count(retry_count), .alert_line_n(alert_line_n));

// File: bench/temperature_fault_supervisor_test.sv
// testbench for the temperature supervisor: registers, trips, lockout and retries
// assumes the host model issues commands and the bound checker watches the ports
`timescale 1ns/1ps
module temperature_fault_supervisor_test;
    import temp_sup_pkg::*;
    localparam int UNIT = 10;
    logic clk = 0, rst_b = 0, temp_valid = 0, enable_req = 0, other_fault_shutdown = 0;
    logic clear_faults = 0, output_enable, alert_line_n;
    logic [15:0] temp_linear = 16'h0000;
    logic [2:0] retry_count;
    cmd_req_t req;
    cmd_rsp_t rsp, r;
    temp_status_t temp_status;
    supervisor_state_t seq_state;
    int mismatches = 0, tests_run = 0, n;
    logic [7:0] codes [5] = '{8'h4F, 8'h50, 8'h51, 8'h52, 8'h53};
    logic [15:0] vals [5] = '{16'h0078, 16'hFF93, 16'h005A, 16'h07EC, 16'h07E2};
    // short retry unit keeps the 280 ms case to 80 cycles
    temperature_fault_supervisor #(.RETRY_UNIT_CYC(UNIT)) i_dut (.clk(clk), .rst_b(rst_b),
        .cmd_req(req), .cmd_rsp(rsp), .temp_linear(temp_linear), .temp_valid(temp_valid),
        .enable_req(enable_req), .other_fault_shutdown(other_fault_shutdown),
        .clear_faults(clear_faults), .output_enable(output_enable),
        .temp_status(temp_status), .seq_state(seq_state), .retry_count(retry_count),
        .alert_line_n(alert_line_n));
    mgmt_host_model i_host (.clk(clk), .cmd_req(req), .cmd_rsp(rsp));
    always #4 clk = ~clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        i_host.xfer(1'b0, code, 16'h0000, r);
        chk("read answer", {14'h0000, r.ack, r.err}, 16'h0002);
        chk("read data", r.rdata, exp);
    endtask
    // bounded wait; running out counts a mismatch and ends the run
    task automatic wait_st(input supervisor_state_t s, output int k);
        k = 0;
        while (seq_state !== s && k < 2000) begin
            cyc(1);
            k++;
        end
        if (k >= 2000) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic clr();
        temp_linear = 16'h0000;
        clear_faults = 1;
        cyc(1);
        clear_faults = 0;
        cyc(1);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_b = 1;
        enable_req = 1;
        temp_valid = 1;
        rd(8'h4F, RST_OT_FAULT_THR);
        rd(8'h50, {8'h00, RST_ACTION});
        rd(8'h51, RST_OT_WARN_THR);
        rd(8'h52, RST_UT_WARN_THR);
        rd(8'h53, RST_UT_FAULT_THR);
        i_host.xfer(1'b0, 8'h54, 16'h0000, r);
        chk("unknown code", {r.rdata[13:0], r.ack, r.err}, 16'h0003);
        for (int i = 0; i < 5; i++) i_host.xfer(1'b1, codes[i], vals[i], r);
        for (int i = 0; i < 5; i++)
            rd(codes[i], i == 1 ? 16'h0093 : vals[i]);
        $display("registers test done");
        // warnings: equal trips, one step short does not
        temp_linear = 16'h0059;
        cyc(2);
        chk("below warn", 16'(temp_status), 16'h0000);
        temp_linear = 16'h005A;
        cyc(2);
        chk("ot warn", {output_enable, alert_line_n, 10'h000, temp_status},
            16'h8002);
        clr();
        chk("cleared", {15'h0000, alert_line_n}, 16'h0001);
        temp_linear = 16'h07EC;
        cyc(2);
        chk("ut warn", 16'(temp_status), 16'h0004);
        temp_linear = 16'h07E2;
        cyc(2);
        chk("ut fault", {output_enable, 11'h000, temp_status}, 16'h800C);
        clr();
        temp_valid = 0;
        temp_linear = 16'h0078;
        cyc(3);
        chk("no valid", 16'(temp_status), 16'h0000);
        temp_valid = 1;
        clr();
        $display("warning test done");
        // responses other than disable-and-retry only flag
        for (int m = 0; m < 4; m++) begin
            if (m == 2) continue;
            i_host.xfer(1'b1, 8'h50, {8'h00, 2'(m), 6'h00}, r);
            temp_linear = 16'h0078;
            cyc(2);
            chk("flag only", {output_enable, alert_line_n, 10'h000, temp_status},
                16'h8003);
            clr();
        end
        // no retry: off at once, locked until cleared
        i_host.xfer(1'b1, 8'h50, 16'h0080, r);
        temp_linear = 16'h0078;
        #1 chk("off at once", {15'h0000, output_enable}, 16'h0000);
        cyc(1);
        temp_linear = 16'h0000;
        cyc(50);
        chk("locked", {13'h0000, output_enable, seq_state}, 16'h0002);
        clr();
        chk("restarted", {13'h0000, output_enable, seq_state}, 16'h0004);
        $display("lockout test done");
        // every delay code, retry budgets 1..4
        for (int d = 0; d < 8; d++) begin
            i_host.xfer(1'b1, 8'h50, {8'h00, 2'b10, 3'(d % 4 + 1), 3'(d)}, r);
            temp_linear = 16'h0078;
            for (int k = 0; k <= d % 4; k++) begin
                wait_st(ST_WAIT, n);
                wait_st(ST_RUN, n);
                chk("retry wait", 16'(n >= (d + 1) * UNIT && n <= (d + 1) * UNIT + 1),
                    16'h0001);
            end
            wait_st(ST_LOCKED, n);
            chk("attempts", {13'h0000, retry_count}, 16'(d % 4 + 1));
            clr();
        end
        $display("retry test done");
        // endless retries stop only on another shutdown or disable
        i_host.xfer(1'b1, 8'h50, 16'h00B8, r);
        temp_linear = 16'h0078;
        repeat (3) begin
            wait_st(ST_WAIT, n);
            wait_st(ST_RUN, n);
        end
        chk("uncounted", {13'h0000, retry_count}, 16'h0000);
        wait_st(ST_WAIT, n);
        other_fault_shutdown = 1;
        cyc(1);
        other_fault_shutdown = 0;
        cyc(1);
        chk("forced off", 16'(seq_state), 16'h0002);
        enable_req = 0;
        cyc(2);
        chk("disabled", {13'h0000, output_enable, seq_state}, 16'h0000);
        enable_req = 1;
        clr();
        chk("back on", {15'h0000, output_enable}, 16'h0001);
        $display("continuous retry test done");
        close_out();
    end
endmodule

// File: verilog/linear_to_fixed.sv
// linear format value to signed fixed point with 16 fraction bits
// assumes the exponent range -16..15, so the shift is never negative
`timescale 1ns/1ps
module linear_to_fixed (
    input  wire logic [15:0]                          lin_value,
    output logic signed [temp_sup_pkg::FIX_W-1:0]     fix_value
);
    import temp_sup_pkg::*;

    logic signed [FIX_W-1:0] mant_ext;
    logic        [5:0]       shift;

    // exact conversion, no rounding: mantissa shifted by exponent plus fraction bits
    always_comb begin
        mant_ext  = FIX_W'(signed'(lin_value[LIN_MANT_MSB:0]));
        shift     = 6'({lin_value[LIN_EXP_MSB], lin_value[LIN_EXP_MSB:LIN_EXP_LSB]})
                    + 6'(FIX_FRAC_BITS);
        fix_value = mant_ext <<< shift;
    end
endmodule

// File: verilog/retry_delay_timer.sv
// restart delay timer: (delay_sel + 1) units of UNIT_CYCLES clocks, then a done pulse
// assumes start and abort are one-cycle pulses or levels from the supervisor
`timescale 1ns/1ps
module retry_delay_timer #(
    parameter int unsigned UNIT_CYCLES = temp_sup_pkg::RETRY_UNIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [2:0] delay_sel,
    output logic            done
);
    import temp_sup_pkg::*;

    localparam int CNT_W = $clog2(UNIT_CYCLES + 1);

    typedef struct packed {
        logic [CNT_W-1:0] tick;
        logic [2:0]       units;
        logic             busy;
        logic             done;
    } timer_state_t;

    timer_state_t s_r;
    timer_state_t s_nxt;

    // abort beats start so a disabled output never restarts
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (abort) begin
            s_nxt.busy = 1'b0;
            s_nxt.tick = '0;
        end else if (start) begin
            s_nxt.busy  = 1'b1;
            s_nxt.tick  = '0;
            s_nxt.units = delay_sel;
        end else if (s_r.busy) begin
            if (s_r.tick == CNT_W'(UNIT_CYCLES - 1)) begin
                s_nxt.tick = '0;
                if (s_r.units == 3'h0) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1; // [RULE11]
                end else begin
                    s_nxt.units = s_r.units - 3'h1;
                end
            end else begin
                s_nxt.tick = s_r.tick + CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
endmodule

// File: verilog/temp_sup_pkg.sv
// temperature supervisor: command codes, field layouts, reset values, timing, types
// assumes one 125 MHz clock and temperatures reported in the 16-bit linear number format
package temp_sup_pkg;

    // command codes of the five supervisor registers
    localparam logic [7:0] CODE_OVERTEMP_FAULT_THRESHOLD   = 8'h4F;
    localparam logic [7:0] CODE_OVERTEMP_FAULT_ACTION      = 8'h50;
    localparam logic [7:0] CODE_OVERTEMP_WARNING_THRESHOLD = 8'h51;
    localparam logic [7:0] CODE_UNDERTEMP_WARNING_THRESHOLD = 8'h52;
    localparam logic [7:0] CODE_UNDERTEMP_FAULT_THRESHOLD  = 8'h53;

    // linear format: signed exponent on top, signed mantissa below
    localparam int LIN_EXP_MSB   = 15;
    localparam int LIN_EXP_LSB   = 11;
    localparam int LIN_MANT_MSB  = 10;
    localparam int FIX_FRAC_BITS = 16;
    localparam int FIX_W         = 48;

    // action byte field values
    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [2:0] RETRY_NONE         = 3'h0;
    localparam logic [2:0] RETRY_FOREVER      = 3'h7;

    // reset values: 125 C, 100 C, -25 C, -40 C with exponent zero
    localparam logic [15:0] RST_OT_FAULT_THR = 16'h007D;
    localparam logic [15:0] RST_OT_WARN_THR  = 16'h0064;
    localparam logic [15:0] RST_UT_WARN_THR  = 16'h07E7;
    localparam logic [15:0] RST_UT_FAULT_THR = 16'h07D8;
    localparam logic [7:0]  RST_ACTION       = 8'h80;

    // retry delay unit: 35 ms per step at an 8 ns clock
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam int unsigned RETRY_UNIT_MS     = 35;
    localparam int unsigned NS_PER_MS         = 1000000;
    localparam int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;

    // action byte as stored
    typedef struct packed {
        logic [1:0] response;
        logic [2:0] retries;
        logic [2:0] delay;
    } fault_action_t;

    // sticky temperature status bits
    typedef struct packed {
        logic ut_fault;
        logic ut_warn;
        logic ot_warn;
        logic ot_fault;
    } temp_status_t;

    // management command request and its answer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } cmd_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } cmd_rsp_t;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_WAIT   = 2'b01,
        ST_LOCKED = 2'b10
    } supervisor_state_t;

endpackage

// File: verilog/temperature_fault_supervisor.sv
// temperature supervisor: four linear thresholds, over-temperature action byte,
// sticky status, alert line and the disable-and-retry sequencer
// assumes commands arrive already decoded from the management bus, one per cycle,
// and the measured temperature arrives in linear format with a valid qualifier
//
// Functional notes
// RULE1 - writable 16-bit linear over-temperature fault threshold, compared to temperature
// RULE2 - writable 16-bit linear over-temperature warning threshold, separate from fault
// RULE3 - writable 16-bit linear under-temperature warning threshold
// RULE4 - writable 16-bit linear under-temperature fault threshold
// RULE5 - thresholds move as words; action code 0x50 moves as a byte
// RULE6 - any over-temperature fault pulls alert low and sets its status bit
// RULE7 - response 10 disables output at once, then applies retry behaviour
// RULE8 - bits 5:3 give the number of restart attempts after shutdown
// RULE9 - retry 000: no restart, output off until the fault is cleared
// RULE10 - retry 111: retry forever until disabled, reset or other shutdown
// RULE11 - wait (bits 2:0 plus one) times 35 ms between restart attempts
// RULE12 - over-trips at or above threshold, under-trips at or below threshold
// RULE13 - warnings set status and alert but leave the output running
`timescale 1ns/1ps
module temperature_fault_supervisor #(
    parameter int unsigned RETRY_UNIT_CYC = temp_sup_pkg::RETRY_UNIT_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire temp_sup_pkg::cmd_req_t     cmd_req,
    output temp_sup_pkg::cmd_rsp_t          cmd_rsp,
    input  wire logic [15:0]                temp_linear,
    input  wire logic                       temp_valid,
    input  wire logic                       enable_req,
    input  wire logic                       other_fault_shutdown,
    input  wire logic                       clear_faults,
    output logic                            output_enable,
    output temp_sup_pkg::temp_status_t      temp_status,
    output temp_sup_pkg::supervisor_state_t seq_state,
    output logic [2:0]                      retry_count,
    output logic                            alert_line_n
);
    import temp_sup_pkg::*;

    localparam int N_THR = 4;

    // all state of the supervisor except the restart timer in one record
    typedef struct packed {
        logic [15:0]       ot_fault_thr;
        logic [15:0]       ot_warn_thr;
        logic [15:0]       ut_warn_thr;
        logic [15:0]       ut_fault_thr;
        fault_action_t     action;
        temp_status_t      status;
        supervisor_state_t state;
        logic [2:0]        attempts;
        cmd_rsp_t          rsp;
    } sup_state_t;

    sup_state_t s_r;
    sup_state_t s_nxt;

    logic [15:0]             thr_raw [N_THR];
    logic signed [FIX_W-1:0] thr_fix [N_THR];
    logic signed [FIX_W-1:0] temp_fix;

    // crossings and the trip they cause
    logic ot_fault_hit;
    logic ot_warn_hit;
    logic ut_warn_hit;
    logic ut_fault_hit;
    logic trip_now;
    logic retry_allowed;

    // restart timer handshake
    logic retry_start;
    logic retry_abort;
    logic retry_done;

    // true for the codes this block answers; used by both the write and read paths
    function automatic logic code_known(input logic [7:0] code);
        case (code)
            CODE_OVERTEMP_FAULT_THRESHOLD,
            CODE_OVERTEMP_FAULT_ACTION,
            CODE_OVERTEMP_WARNING_THRESHOLD,
            CODE_UNDERTEMP_WARNING_THRESHOLD,
            CODE_UNDERTEMP_FAULT_THRESHOLD: code_known = 1'b1;
            default:                        code_known = 1'b0;
        endcase
    endfunction

    // read value for a code, byte register zero-extended to the word
    function automatic logic [15:0] read_value(input logic [7:0] code,
                                               input sup_state_t st);
        case (code)
            CODE_OVERTEMP_FAULT_THRESHOLD:    read_value = st.ot_fault_thr;
            CODE_OVERTEMP_FAULT_ACTION:       read_value = {8'h00, st.action}; // [RULE5]
            CODE_OVERTEMP_WARNING_THRESHOLD:  read_value = st.ot_warn_thr;
            CODE_UNDERTEMP_WARNING_THRESHOLD: read_value = st.ut_warn_thr;
            CODE_UNDERTEMP_FAULT_THRESHOLD:   read_value = st.ut_fault_thr;
            default:                          read_value = 16'h0000;
        endcase
    endfunction

    // thresholds in a fixed order for the converters
    assign thr_raw[0] = s_r.ot_fault_thr;
    assign thr_raw[1] = s_r.ot_warn_thr;
    assign thr_raw[2] = s_r.ut_warn_thr;
    assign thr_raw[3] = s_r.ut_fault_thr;

    // linear values become plain signed numbers so one compare covers any exponent
    linear_to_fixed u_temp_conv (
        .lin_value (temp_linear),
        .fix_value (temp_fix)
    );

    // one converter per limit, pure logic
    for (genvar gi = 0; gi < N_THR; gi++) begin : g_thr_conv
        linear_to_fixed u_thr_conv (
            .lin_value (thr_raw[gi]),
            .fix_value (thr_fix[gi])
        );
    end

    // threshold crossings, only while a measurement is valid
    // equality counts as a crossing
    always_comb begin
        ot_fault_hit = temp_valid && (temp_fix >= thr_fix[0]); // [RULE1] [RULE12]
        ot_warn_hit  = temp_valid && (temp_fix >= thr_fix[1]); // [RULE2] [RULE12]
        ut_warn_hit  = temp_valid && (temp_fix <= thr_fix[2]); // [RULE3] [RULE12]
        ut_fault_hit = temp_valid && (temp_fix <= thr_fix[3]); // [RULE4] [RULE12]
    end

    // a shutdown trip needs the running state and the disable-and-retry response;
    // other responses only flag the fault and leave the output alone
    assign trip_now = (s_r.state == ST_RUN) && enable_req && ot_fault_hit
                      && (s_r.action.response == RESP_DISABLE_RETRY); // [RULE7]

    // a restart is granted for retry-forever or while attempts remain
    always_comb begin
        if (s_r.action.retries == RETRY_NONE) begin
            retry_allowed = 1'b0; // [RULE9]
        end else if (s_r.action.retries == RETRY_FOREVER) begin
            retry_allowed = 1'b1; // [RULE10]
        end else begin
            retry_allowed = (s_r.attempts < s_r.action.retries); // [RULE8]
        end
    end

    // a trip with budget left arms the timer
    assign retry_start = trip_now && retry_allowed;
    // disable or a foreign shutdown ends any pending restart
    assign retry_abort = !enable_req || other_fault_shutdown; // [RULE10]

    // delay between restart attempts
    retry_delay_timer #(
        .UNIT_CYCLES (RETRY_UNIT_CYC)
    ) u_retry_timer (
        .clk       (clk),
        .rst_b     (rst_b),
        .start     (retry_start),
        .abort     (retry_abort),
        .delay_sel (s_r.action.delay),
        .done      (retry_done)
    );

    // next state: command port, sticky status and the restart sequencer
    always_comb begin
        s_nxt     = s_r;
        s_nxt.rsp = '0;

        // commands: answer one cycle after the request
        if (cmd_req.valid) begin
            // no back-pressure: answer every cycle
            s_nxt.rsp.ack = 1'b1;
            s_nxt.rsp.err = !code_known(cmd_req.code);
            // unknown reads answer zero
            if (!cmd_req.write) begin
                s_nxt.rsp.rdata = read_value(cmd_req.code, s_r);
            end else begin
                case (cmd_req.code)
                    CODE_OVERTEMP_FAULT_THRESHOLD: begin
                        s_nxt.ot_fault_thr = cmd_req.wdata; // [RULE1] [RULE5]
                    end
                    CODE_OVERTEMP_FAULT_ACTION: begin
                        s_nxt.action = fault_action_t'(cmd_req.wdata[7:0]); // [RULE5]
                    end
                    CODE_OVERTEMP_WARNING_THRESHOLD: begin
                        s_nxt.ot_warn_thr = cmd_req.wdata; // [RULE2] [RULE5]
                    end
                    CODE_UNDERTEMP_WARNING_THRESHOLD: begin
                        s_nxt.ut_warn_thr = cmd_req.wdata; // [RULE3] [RULE5]
                    end
                    CODE_UNDERTEMP_FAULT_THRESHOLD: begin
                        s_nxt.ut_fault_thr = cmd_req.wdata; // [RULE4] [RULE5]
                    end
                    default: begin
                        // refused: nothing stored
                        s_nxt.rsp.err = 1'b1;
                    end
                endcase
            end
        end

        // sticky status: a new crossing in the clear cycle survives the clear
        if (clear_faults) begin
            s_nxt.status = '0;
        end
        // set under every response mode
        if (ot_fault_hit) begin
            s_nxt.status.ot_fault = 1'b1; // [RULE6]
        end
        // warnings never reach the sequencer
        if (ot_warn_hit) begin
            s_nxt.status.ot_warn = 1'b1; // [RULE13]
        end
        if (ut_warn_hit) begin
            s_nxt.status.ut_warn = 1'b1; // [RULE13]
        end
        // under-temperature fault only flags
        if (ut_fault_hit) begin
            s_nxt.status.ut_fault = 1'b1;
        end

        // restart sequencer
        case (s_r.state)
            ST_RUN: begin
                if (trip_now) begin
                    if (other_fault_shutdown) begin
                        // aborted timer: a wait would never end
                        s_nxt.state = ST_LOCKED; // [RULE10]
                    end else if (!retry_allowed) begin
                        s_nxt.state = ST_LOCKED; // [RULE9]
                    end else begin
                        s_nxt.state = ST_WAIT;
                        // the forever count is not tracked, it never runs out
                        if (s_r.action.retries != RETRY_FOREVER) begin
                            s_nxt.attempts = s_r.attempts + 3'h1; // [RULE8]
                        end
                    end
                end
            end

            ST_WAIT: begin
                // left by timer pulse, foreign shutdown or dropped enable
                if (other_fault_shutdown) begin
                    s_nxt.state = ST_LOCKED; // [RULE10]
                end else if (retry_done) begin
                    s_nxt.state = ST_RUN; // [RULE11]
                end
            end

            ST_LOCKED: begin
                // output stays off until software clears the faults or toggles the enable
                if (clear_faults) begin
                    s_nxt.state = ST_RUN; // [RULE9]
                end
            end

            default: begin
                // unused codes fail safe, output off
                s_nxt.state = ST_LOCKED;
            end
        endcase

        // clearing faults or dropping the enable starts the attempt budget afresh
        if (clear_faults) begin
            s_nxt.attempts = 3'h0;
        end

        // disable ends any wait or lockout
        if (!enable_req) begin
            s_nxt.state    = ST_RUN; // [RULE10]
            s_nxt.attempts = 3'h0;
        end
    end

    // state register
    // asynchronous clear, synchronous use
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // thresholds and action at package defaults
            s_r              <= '0;
            s_r.ot_fault_thr <= RST_OT_FAULT_THR;
            s_r.ot_warn_thr  <= RST_OT_WARN_THR;
            s_r.ut_warn_thr  <= RST_UT_WARN_THR;
            s_r.ut_fault_thr <= RST_UT_FAULT_THR;
            s_r.action       <= fault_action_t'(RST_ACTION);
            s_r.state        <= ST_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    // output drops in the very cycle of the trip, not one clock later
    assign output_enable = enable_req && (s_r.state == ST_RUN) && !trip_now; // [RULE7]

    // any sticky bit holds the alert low; warnings never touch the output
    assign alert_line_n = !(|s_r.status); // [RULE6] [RULE13]

    // registered views for host and board
    assign temp_status = s_r.status;
    assign seq_state   = s_r.state;
    assign retry_count = s_r.attempts;
    assign cmd_rsp     = s_r.rsp;

endmodule
